/* File: sar_adc10_pkg.sv */
`default_nettype none
package sar_adc10_pkg;
  // Conversion start sources selected by the start-mode field
  typedef enum logic [1:0] {
    START_SW    = 2'b00,   // Write of one to the busy bit
    START_TMR3  = 2'b01,   // Timer 3 overflow
    START_EXT   = 2'b10,   // Rising edge on the external start input
    START_TMR2  = 2'b11    // Timer 2 overflow
  } start_mode_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,      // Tracking in default mode, waiting for a start
    ST_TRACK = 2'b01,      // Low-power tracking interval
    ST_SAR   = 2'b10,      // Successive-approximation steps
    ST_DONE  = 2'b11       // Result capture, busy falls next
  } seq_state_t;

  // Configuration bundle from software
  typedef struct packed {
    logic        enable;        // Converter enable bit
    logic        leftJustify;   // Left justify bit
    logic        trackMode;     // Low-power tracking mode bit
    start_mode_t startMode;     // Start-mode field
    logic [4:0]  clkDiv;        // Clock divider field
    logic [3:0]  channelCode;   // Multiplexer channel code
    logic [3:0]  pairConfig;    // Pair-configuration bits, pair 01 at bit 0
  } adc_cfg_t;

  // Timer overflow bundle
  typedef struct packed {
    logic lowOvf;   // Low-byte overflow
    logic highOvf;  // High-byte overflow
    logic mode16;   // Timer in 16-bit mode
  } timer_ovf_t;

  localparam int          RES_BITS      = 10;     // Converter resolution
  localparam int          SAR_STEPS     = 10;     // One bit decided per converter clock
  localparam logic [1:0]  TRACK_CLOCKS  = 2'h3;   // Low-power tracking interval
  localparam logic [3:0]  SAR_LAST      = 4'h9;   // Last step index
  localparam logic [3:0]  TEMP_CHANNEL  = 4'h8;   // Channel code of temperature sensor
  localparam logic [4:0]  CLKDIV_RESET  = 5'h1f;  // Divider field after reset
  localparam int          CHAN_COUNT    = 8;      // External analog inputs
  localparam int          SYS_CLK_HZ    = 20000000;
  localparam int          MAX_CONV_HZ   = 3000000;  // Software should stay under this
  // Smallest divider field meeting the converter clock ceiling, rounded up
  localparam int          MIN_CLKDIV    = (SYS_CLK_HZ + MAX_CONV_HZ - 1) / MAX_CONV_HZ - 1;
endpackage
`default_nettype wire

/* File: sar_adc10_control.sv */
// Notes on behaviour
// - Single-ended result is 10-bit unsigned code
// - Justify bit picks right or left alignment
// - Unused single-ended result bits read zero
// - Differential result is 10-bit two's complement
// - Right-justified differential sign-extends upper bits
// - Left-justified differential clears unused low bits
// - Even code plus first pin, odd reversed
// - Converter clock is system clock over field+1
// - Start-mode field picks one of four sources
// - Busy high for whole conversion, then cleared
// - Busy falling edge sets done flag, interrupt
// - Data valid whenever done flag is set
// - Timer 8-bit uses low, 16-bit high overflow
// - Default mode tracks except while converting
// - Low-power mode tracks three clocks after start
// - External start low-power tracks while input low
// - Temperature sensor selectable, always single-ended
// - Crossbar skips pins used as converter inputs
// - Converter runs only while enable bit set
// - Pair bit zero single-ended, one differential
`timescale 1ns/1ns
`default_nettype none
module sar_adc10_control (
  input  wire logic                      mclk,            // 20 MHz system clock
  input  wire logic                      rst,             // Synchronous, active high
  input  wire sar_adc10_pkg::adc_cfg_t   cfg,             // Software configuration
  input  wire logic                      busyWrite,       // Software writes one to busy bit
  input  wire logic                      doneClear,       // Software clears the done flag
  input  wire logic                      intEnable,       // Converter interrupt enable
  input  wire sar_adc10_pkg::timer_ovf_t timer2,          // Timer 2 overflows
  input  wire sar_adc10_pkg::timer_ovf_t timer3,          // Timer 3 overflows
  input  wire logic                      externalStartIn, // External start pin
  input  wire logic                      compHigh,        // Analog comparator result
  input  wire logic [7:0]                portInputMode,   // One marks a pin as analog input
  output logic                           conversionBusy,  // Busy bit
  output logic                           conversionDone,  // Done flag, sticky
  output logic                           irqReq,          // Interrupt request level
  output logic [7:0]                     resultHigh,      // High result byte
  output logic [7:0]                     resultLow,       // Low result byte
  output logic [3:0]                     muxPos,          // Positive input select
  output logic [3:0]                     muxNeg,          // Negative input select
  output logic                           muxDiff,         // Negative leg used
  output logic                           trackOn,         // Track-and-hold tracking
  output logic                           converterOn,     // Analog core powered
  output logic [9:0]                     dacCode,         // Trial code to the comparator
  output logic [7:0]                     crossbarSkip     // Pins hidden from the crossbar
);
  import sar_adc10_pkg::*;

  // Returns whether a channel code lands on a differential pair
  // Shared by the sequencer and the mux steering so both agree on the mode
  function automatic logic isDiff(input logic [3:0] code, input logic [3:0] pairs);
    isDiff = !code[3] && pairs[code[2:1]];
  endfunction

  // External pin synchroniser, three stages; only the later two are compared
  // Released pin idles high, so reset loads ones: leaving reset is no edge
  logic [2:0] extSync_q, extSync_d;
  logic       extLevel_q, extLevel_d;     // Filtered pin level
  always_comb begin
    extSync_d  = {extSync_q[1:0], externalStartIn};
    extLevel_d = extLevel_q;
    if (extSync_q[2] == extSync_q[1]) begin
      extLevel_d = extSync_q[2];
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      extSync_q  <= 3'h7;
      extLevel_q <= 1'b1;
    end else begin
      extSync_q  <= extSync_d;
      extLevel_q <= extLevel_d;
    end
  end
  // Built from the next filtered level so a start is not a cycle late
  logic extRise;                          // One-cycle rising edge of the filtered pin
  assign extRise = extLevel_d && !extLevel_q;

  // Start source selection
  // Pulses of the sources not selected are ignored
  // A 16-bit timer also wraps its low byte; only its high wrap counts there
  logic startPulse;
  always_comb begin
    case (cfg.startMode)
      START_SW:   startPulse = busyWrite;
      START_TMR3: startPulse = timer3.mode16 ? timer3.highOvf : timer3.lowOvf;
      START_EXT:  startPulse = extRise;
      START_TMR2: startPulse = timer2.mode16 ? timer2.highOvf : timer2.lowOvf;
      default:    startPulse = 1'b0;
    endcase
  end

  // Converter clock divider: tick every clkDiv+1 system clocks
  // Free-running while enabled: the first tick of a conversion may come
  // early, which shortens only the first converter clock
  logic [4:0] divCnt_q, divCnt_d;
  logic       sarTick;
  always_comb begin
    sarTick  = (divCnt_q >= cfg.clkDiv);
    divCnt_d = sarTick ? 5'h00 : divCnt_q + 5'h01;
    if (!cfg.enable) begin
      divCnt_d = 5'h00;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      divCnt_q <= 5'h00;
    end else begin
      divCnt_q <= divCnt_d;
    end
  end

  // Sequencer: tracking, successive approximation, result capture
  // The next-value process gives every register of this group a value
  // on every path, so no latch can appear
  seq_state_t state_q, state_d;
  logic [1:0] trackCnt_q, trackCnt_d;     // Converter clocks spent tracking
  logic [3:0] step_q, step_d;             // Current bit step, 0 is the MSB
  logic [9:0] sar_q, sar_d;               // Approximation register
  logic [9:0] trial;                      // Current trial code
  logic       diff_q, diff_d;             // Mode latched at the start
  // Result bytes stand until the next conversion ends
  logic [7:0] resHigh_q, resHigh_d;
  logic [7:0] resLow_q, resLow_d;
  // Busy bit, done flag and request level
  logic       busy_q, busy_d;
  logic       done_q, done_d;
  logic       irq_q, irq_d;
  logic       extWaiting;                 // Low-power external mode waits on pin high
  logic [9:0] code;                       // Final code, offset binary from the core
  logic [9:0] signedCode;

  always_comb begin
    trial      = sar_q | (10'h200 >> step_q);
    extWaiting = cfg.trackMode && (cfg.startMode == START_EXT);
    state_d    = state_q;
    trackCnt_d = trackCnt_q;
    step_d     = step_q;
    sar_d      = sar_q;
    diff_d     = diff_q;
    resHigh_d  = resHigh_q;
    resLow_d   = resLow_q;
    busy_d     = busy_q;
    done_d     = done_q && !doneClear;
    code       = sar_q;
    // Core compares in offset binary; flip MSB for two's complement
    signedCode = {~code[9], code[8:0]};
    case (state_q)
      ST_IDLE: begin
        if (cfg.enable && startPulse) begin
          busy_d     = 1'b1;
          diff_d     = isDiff(cfg.channelCode, cfg.pairConfig);
          trackCnt_d = 2'h0;
          step_d     = 4'h0;
          sar_d      = 10'h000;
          // Pin-started low-power mode already tracked while the pin was low
          state_d    = (cfg.trackMode && !extWaiting) ? ST_TRACK : ST_SAR;
        end
      end
      ST_TRACK: begin
        // Three converter clocks on the sampling capacitor before any decision
        if (sarTick) begin
          trackCnt_d = trackCnt_q + 2'h1;
          if (trackCnt_q == TRACK_CLOCKS - 2'h1) begin
            state_d = ST_SAR;
          end
        end
      end
      ST_SAR: begin
        // Keep the trial bit only when the input is at or above the trial code
        if (sarTick) begin
          sar_d  = compHigh ? trial : sar_q;
          step_d = step_q + 4'h1;
          if (step_q == SAR_LAST) begin
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // Both bytes land together, on the same edge that busy falls
        if (diff_q) begin
          if (cfg.leftJustify) begin
            {resHigh_d, resLow_d} = {signedCode, 6'h00};
          end else begin
            {resHigh_d, resLow_d} = {{6{signedCode[9]}}, signedCode};
          end
        end else begin
          if (cfg.leftJustify) begin
            {resHigh_d, resLow_d} = {code, 6'h00};
          end else begin
            {resHigh_d, resLow_d} = {6'h00, code};
          end
        end
        busy_d  = 1'b0;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    // Busy falling edge sets the flag; set wins over a same-cycle clear
    if (busy_q && !busy_d) begin
      done_d = 1'b1;
    end
    // Request is a level that follows the flag while the interrupt is enabled
    irq_d = done_d && intEnable;
    // Disabling aborts any conversion and parks the core
    // An abort never sets the done flag: no valid data stands behind it
    if (!cfg.enable) begin
      state_d = ST_IDLE;
      busy_d  = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      trackCnt_q <= 2'h0;
      step_q     <= 4'h0;
      sar_q      <= 10'h000;
      diff_q     <= 1'b0;
      resHigh_q  <= 8'h00;
      resLow_q   <= 8'h00;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      trackCnt_q <= trackCnt_d;
      step_q     <= step_d;
      sar_q      <= sar_d;
      diff_q     <= diff_d;
      resHigh_q  <= resHigh_d;
      resLow_q   <= resLow_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      irq_q      <= irq_d;
    end
  end

  // Analog steering, all registered so outputs come from flip-flops
  // Mux follows the code at once, so a change mid-conversion spoils it
  logic [3:0] muxPos_q, muxPos_d, muxNeg_q, muxNeg_d;
  logic       muxDiff_q, muxDiff_d, track_q, track_d, on_q, on_d;
  logic [9:0] dac_q, dac_d;
  logic [7:0] skip_q, skip_d;
  always_comb begin
    muxPos_d  = cfg.channelCode;
    muxDiff_d = isDiff(cfg.channelCode, cfg.pairConfig);
    // Odd code of a pair swaps the legs
    muxNeg_d  = {cfg.channelCode[3:1], ~cfg.channelCode[0]};
    // Single-ended inputs leave the negative leg on ground
    if (!muxDiff_d) begin
      muxNeg_d = 4'h0;
    end
    if (extWaiting) begin
      track_d = cfg.enable && (state_q == ST_IDLE) && !extLevel_q;
    end else if (cfg.trackMode) begin
      track_d = cfg.enable && (state_q == ST_TRACK);
    end else begin
      track_d = cfg.enable && (state_q == ST_IDLE);
    end
    on_d   = cfg.enable;
    // Next trial leaves its flop together with the state, so the comparator
    // has settled even when the first converter tick comes at once
    dac_d  = (state_d == ST_SAR) ? (sar_d | (10'h200 >> step_d)) : sar_d;
    // Pins marked analog are never handed to digital functions
    skip_d = portInputMode;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      muxPos_q  <= 4'h0;
      muxNeg_q  <= 4'h0;
      muxDiff_q <= 1'b0;
      track_q   <= 1'b0;
      on_q      <= 1'b0;
      dac_q     <= 10'h000;
      skip_q    <= 8'h00;
    end else begin
      muxPos_q  <= muxPos_d;
      muxNeg_q  <= muxNeg_d;
      muxDiff_q <= muxDiff_d;
      track_q   <= track_d;
      on_q      <= on_d;
      dac_q     <= dac_d;
      skip_q    <= skip_d;
    end
  end

  // Every output leaves straight from its flip-flop
  assign conversionBusy = busy_q;
  assign conversionDone = done_q;
  assign irqReq         = irq_q;
  assign resultHigh     = resHigh_q;
  assign resultLow      = resLow_q;
  assign muxPos         = muxPos_q;
  assign muxNeg         = muxNeg_q;
  assign muxDiff        = muxDiff_q;
  assign trackOn        = track_q;
  assign converterOn    = on_q;
  assign dacCode        = dac_q;
  assign crossbarSkip   = skip_q;
endmodule // sar_adc10_control
`default_nettype wire

/* File: sar_adc10_props.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_adc10_props (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire sar_adc10_pkg::adc_cfg_t    cfg,
  input wire logic                       busyWrite,
  input wire logic                       doneClear,
  input wire logic                       intEnable,
  input wire sar_adc10_pkg::timer_ovf_t  timer3,
  input wire logic                       conversionBusy,
  input wire logic                       conversionDone,
  input wire logic                       irqReq,
  input wire logic [7:0]                 resultHigh,
  input wire logic [7:0]                 resultLow,
  input wire logic [3:0]                 muxPos,
  input wire logic [3:0]                 muxNeg,
  input wire logic                       muxDiff,
  input wire logic                       converterOn,
  input wire logic [7:0]                 portInputMode,
  input wire logic [7:0]                 crossbarSkip
);
  import sar_adc10_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Software start while idle and enabled
  sequence s_swStart;
    cfg.enable && cfg.startMode == START_SW && busyWrite && !conversionBusy;
  endsequence
  // Busy held, then released in bounded time
  sequence s_convRun;
    conversionBusy[*8] ##[0:500] !conversionBusy;
  endsequence
  // End of a conversion that ran enabled
  sequence s_busyEnd;
    $fell(conversionBusy) && $past(cfg.enable) && !$past(rst);
  endsequence
  a_sw_start_busy: assert property (s_swStart |=> s_convRun)
    else $error("busy not held through conversion");
  a_fall_sets_done: assert property (s_busyEnd |-> conversionDone)
    else $error("done not set at busy fall");
  a_irq_follows: assert property (
    !$past(rst) |-> irqReq == (conversionDone & $past(intEnable)))
    else $error("irq not following done");
  a_done_hold: assert property (conversionDone && !doneClear |=> conversionDone)
    else $error("done dropped without clear");
  a_done_clear: assert property (doneClear && !conversionBusy |=> !conversionDone)
    else $error("done not cleared");
  a_right_pad: assert property (
    s_busyEnd ##0 !$past(cfg.leftJustify) |-> resultHigh[7:2] == {6{muxDiff & resultHigh[1]}})
    else $error("upper bits not zero or sign");
  a_left_pad: assert property (
    s_busyEnd ##0 $past(cfg.leftJustify) |-> resultLow[5:0] == 6'h00)
    else $error("lower bits not zero");
  a_off_idle: assert property (!cfg.enable |=> !conversionBusy && !converterOn)
    else $error("converter active while disabled");
  a_timer_start: assert property (
    cfg.enable && cfg.startMode == START_TMR3 && !conversionBusy |=> conversionBusy ==
      ($past(timer3.mode16) ? $past(timer3.highOvf) : $past(timer3.lowOvf)))
    else $error("wrong timer overflow used");
  a_skip_pins: assert property (!$past(rst) |-> crossbarSkip == $past(portInputMode))
    else $error("crossbar skip wrong");
  a_diff_pair: assert property (muxDiff |-> muxNeg == (muxPos ^ 4'h1))
    else $error("pair polarity wrong");
  a_temp_single: assert property (muxPos >= TEMP_CHANNEL |-> !muxDiff)
    else $error("sensor measured differentially");
endmodule // sar_adc10_props
bind sar_adc10_control sar_adc10_props props_u (.mclk, .rst, .cfg, .busyWrite, .doneClear,
  .intEnable, .timer3, .conversionBusy, .conversionDone, .irqReq, .resultHigh, .resultLow,
  .muxPos, .muxNeg, .muxDiff, .converterOn, .portInputMode, .crossbarSkip);
`default_nettype wire

/* File: start_source_model.sv */
`timescale 1ns/1ns
`default_nettype none
module start_source_model (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      fireT2,          // Ask timer 2 to overflow
  input  wire logic                      fireT3,          // Ask timer 3 to overflow
  input  wire logic                      mode16,          // Timers in 16-bit mode
  input  wire logic                      pinLow,          // Pull start pin low
  input  wire logic [9:0]                target,          // Analog input as core code
  input  wire logic [9:0]                dacCode,         // Trial code
  output var  sar_adc10_pkg::timer_ovf_t timer2,
  output var  sar_adc10_pkg::timer_ovf_t timer3,
  output logic                           externalStartIn, // Pulled up when released
  output logic                           compHigh         // Input at or above trial
);
  import sar_adc10_pkg::*;
  logic [2:0] hist2_q, hist3_q;  // Overflow history per timer
  // A 16-bit timer wraps its low byte alone before the high one
  always_ff @(posedge mclk) begin
    if (rst) begin
      hist2_q <= 3'h0;
      hist3_q <= 3'h0;
    end else begin
      hist2_q <= {hist2_q[1:0], fireT2};
      hist3_q <= {hist3_q[1:0], fireT3};
    end
  end
  // Low-only pulse first, then both together in 16-bit mode
  assign timer2 = '{lowOvf: hist2_q[0] | (mode16 & hist2_q[2]),
    highOvf: mode16 & hist2_q[2], mode16: mode16};
  assign timer3 = '{lowOvf: hist3_q[0] | (mode16 & hist3_q[2]),
    highOvf: mode16 & hist3_q[2], mode16: mode16};
  assign externalStartIn = ~pinLow;  // Open drain pin
  assign compHigh = (target >= dacCode);  // Ideal comparator
endmodule // start_source_model
`default_nettype wire

/* File: sar_adc10_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_adc10_control_bench;
  import sar_adc10_pkg::*;
  typedef struct packed {
    logic [15:0] res;  // Result word
    logic [15:0] lo;   // Shortest busy time
    logic [15:0] hi;   // Longest busy time
  } note_t;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  adc_cfg_t    cfg;
  timer_ovf_t  timer2, timer3;
  logic        busyWrite, doneClear, intEnable, externalStartIn, compHigh;
  logic        fireT2, fireT3, mode16, pinLow;
  logic        conversionBusy, conversionDone, irqReq, muxDiff, trackOn, converterOn;
  logic [7:0]  resultHigh, resultLow, portInputMode, crossbarSkip;
  logic [3:0]  muxPos, muxNeg;
  logic [9:0]  dacCode, target;
  logic [31:0] rnd;
  note_t       q[$];  // Expected results, oldest first
  note_t       e;
  int          n_errors, compares, busyLen, i;
  sar_adc10_control dut_u (.mclk, .rst, .cfg, .busyWrite, .doneClear, .intEnable, .timer2,
    .timer3, .externalStartIn, .compHigh, .portInputMode, .conversionBusy, .conversionDone,
    .irqReq, .resultHigh, .resultLow, .muxPos, .muxNeg, .muxDiff, .trackOn, .converterOn,
    .dacCode, .crossbarSkip);
  start_source_model far_u (.mclk, .rst, .fireT2, .fireT3, .mode16, .pinLow, .target,
    .dacCode, .timer2, .timer3, .externalStartIn, .compHigh);
  always #25 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Core code is offset binary; differential flips the top bit
  function automatic logic [15:0] fmt(input logic [9:0] t, input logic d, input logic l);
    logic [9:0] c;
    c = d ? (t ^ 10'h200) : t;
    return l ? {c, 6'h00} : {{6{d & c[9]}}, c};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk);
    #5;
  endtask
  // Bounded wait for a busy level
  task automatic waitBusy(input logic lvl);
    int n;
    for (n = 0; n < 600 && conversionBusy !== lvl; n++) tick();
    if (n == 600) begin
      check("busyWait", {15'h0, conversionBusy}, {15'h0, lvl});
      print_verdict();
    end
  endtask
  // One conversion; length bounds allow an early first tick
  task automatic run(input start_mode_t src, input logic [15:0] res);
    logic [15:0] d, t;
    d = 16'(cfg.clkDiv) + 16'h1;
    t = (cfg.trackMode && src != START_EXT) ? 16'h000d : 16'h000a;
    cfg.startMode = src;
    doneClear = 1'b1;
    pinLow = 1'b1;
    tick();
    doneClear = 1'b0;
    q.push_back('{res, (t - 16'h1) * d + 16'h1, t * d + 16'h2});
    case (src)
      START_SW: busyWrite = 1'b1;
      START_TMR3: fireT3 = 1'b1;
      START_TMR2: fireT2 = 1'b1;
      default: begin
        repeat (4) tick();
        if (cfg.trackMode) check("track", {15'h0, trackOn}, 16'h1);
      end
    endcase
    pinLow = 1'b0;
    tick();
    {busyWrite, fireT2, fireT3} = 3'h0;
    if (src == START_TMR2 || src == START_TMR3) begin
      tick();
      check("timerStart", {15'h0, conversionBusy}, {15'h0, !mode16});
    end
    waitBusy(1'b1);
    waitBusy(1'b0);
    repeat (2) tick();
  endtask
  // Result monitor: compares at each completion
  always @(posedge mclk) begin
    #2;
    if (conversionBusy === 1'b1) busyLen++;
    else if (busyLen != 0) begin
      if (conversionDone === 1'b1 && q.size() > 0) begin
        e = q.pop_front();
        check("result", {resultHigh, resultLow}, e.res);
        check("busyTime", {15'h0, 16'(busyLen) >= e.lo && 16'(busyLen) <= e.hi}, 16'h1);
        check("irq", {15'h0, irqReq}, {15'h0, intEnable});
      end
      busyLen = 0;
    end
  end
  initial begin
    cfg = '0;
    {busyWrite, doneClear, intEnable, fireT2, fireT3, mode16, pinLow} = 7'h00;
    target = 10'h000;
    portInputMode = 8'h00;
    rnd = 32'h61fb;
    repeat (20) tick();
    rst = 1'b0;
    cfg.enable = 1'b1;
    cfg.pairConfig = 4'h1;
    // Every format, source, divider end and tracking mode
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      cfg.leftJustify = i[0];
      cfg.channelCode = i[1] ? 4'h2 : {3'h0, i[3]};  // Pair 01 either polarity, input 2 single
      cfg.trackMode = i[2];
      cfg.clkDiv = i[3] ? 5'h1f : 5'(MIN_CLKDIV);
      mode16 = i[0] ^ i[3];
      intEnable = i[1];
      portInputMode = rnd[15:8];
      target = i[3] ? (i[2] ? rnd[9:0] : 10'h200) : (i[2] ? 10'h000 : 10'h3ff);
      run(start_mode_t'(i[1:0] ^ i[3:2]), fmt(target, !i[1], i[0]));
      check("mux", {8'h0, muxPos, muxNeg}, {8'h0, cfg.channelCode, 3'h0, !i[1] & !i[3]});
      check("muxDiff", {15'h0, muxDiff}, {15'h0, !i[1]});
      check("trackIdle", {15'h0, trackOn}, {15'h0, !i[2]});
      check("skip", {8'h0, crossbarSkip}, {8'h0, portInputMode});
    end
    check("converterOn", {15'h0, converterOn}, 16'h1);
    $display("test formats done");
    cfg.pairConfig = 4'hf;
    cfg.channelCode = TEMP_CHANNEL;
    run(START_SW, fmt(target, 1'b0, cfg.leftJustify));
    $display("test sensor done");
    // Abort mid conversion, then a refused start
    doneClear = 1'b1;
    busyWrite = 1'b1;
    tick();
    {doneClear, busyWrite} = 2'h0;
    repeat (12) tick();
    cfg.enable = 1'b0;
    waitBusy(1'b0);
    check("doneAfterAbort", {15'h0, conversionDone}, 16'h0);
    busyWrite = 1'b1;
    tick();
    busyWrite = 1'b0;
    tick();
    check("busyDisabled", {15'h0, conversionBusy}, 16'h0);
    check("converterOff", {15'h0, converterOn}, 16'h0);
    check("pending", 16'(q.size()), 16'h0);
    $display("test abort done");
    print_verdict();
  end
endmodule // sar_adc10_control_bench
`default_nettype wire
